// File: gpio_bank_consts.svh
// constants for the ten-pad gpio bank: register offsets, field positions,
// reset values and indicator timing; included by the package users
`ifndef GPIO_BANK_CONSTS_SVH
`define GPIO_BANK_CONSTS_SVH

`define NUM_PADS 10
`define ADDR_W 8
// register byte offsets
`define REG_DIR 8'h00
`define REG_OUT 8'h04
`define REG_IN 8'h08
`define REG_ALT 8'h0c
`define REG_STATE 8'h10
`define REG_LEVEL 8'h14
// status-indicator state field (REG_STATE bits 2:0)
`define STATE_LSB 0
`define STATE_W 3
// reset values
`define DIR_RST 10'h000
`define OUT_RST 10'h000
`define ALT_RST 1'b0
`define STATE_RST 3'h0
// indicator timing, in milliseconds at a 50 MHz clock (20 ns)
`define CLK_HZ 50000000
`define LED_ON_MS 1000
`define LED_OFF_MS 2000
`define MS_TO_CYC(ms) ((ms) * (`CLK_HZ / 1000))
// axi response codes
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// File: gpio_bank_pkg.sv
// types shared by the gpio bank and its status indicator
// assumes gpio_bank_consts.svh is on the include path
`include "gpio_bank_consts.svh"

package gpio_bank_pkg;

  // network condition driving the indicator pattern
  typedef enum logic [2:0] {
    NET_OFF = 3'h0,
    NET_UNREG = 3'h1,
    NET_IDLE = 3'h2,
    NET_PSM = 3'h3,
    NET_CONNECTING = 3'h4
  } net_state_t;

  // one pad bank's pin bundle toward the pads
  typedef struct packed {
    logic [`NUM_PADS-1:0] o;
    logic [`NUM_PADS-1:0] oe;
    logic [`NUM_PADS-1:0] weak_pull_down;
  } pad_drive_t;

endpackage

// File: status_blinker.sv
// status indicator pattern generator for the first pad's alternate function
// assumes a 50 MHz clock and a net state held steady by the caller
`timescale 1ns/1ps
`include "gpio_bank_consts.svh"

module status_blinker
  import gpio_bank_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire net_state_t net_state,
  input wire logic wake_evt,
  output logic led
);

  localparam int unsigned ON_CYC = `MS_TO_CYC(`LED_ON_MS);
  localparam int unsigned PERIOD_CYC = `MS_TO_CYC(`LED_ON_MS + `LED_OFF_MS);

  logic [27:0] cnt_q;
  logic blinking;
  logic psm_q;

  assign blinking = (net_state == NET_IDLE) || (net_state == NET_CONNECTING);

  // ---------------------------------------------------------------
  // blink timer
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !blinking) begin
      cnt_q <= 28'h0000000;
    end else if (cnt_q == 28'(PERIOD_CYC - 1)) begin
      cnt_q <= 28'h0000000;
    end else begin
      cnt_q <= cnt_q + 28'h0000001;
    end
  end

  // psm level toggles on wake events in NET_PSM and clears in any other state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      psm_q <= 1'b0;
    end else if (net_state == NET_PSM) begin
      if (wake_evt) begin
        psm_q <= ~psm_q;
      end
    end else begin
      psm_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // pattern select
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led <= 1'b0;
    end else begin
      unique case (net_state)
        NET_OFF: led <= 1'b0;
        NET_UNREG: led <= 1'b1;
        NET_IDLE: led <= (cnt_q < 28'(ON_CYC));
        NET_CONNECTING: led <= (cnt_q < 28'(ON_CYC));
        NET_PSM: led <= psm_q;
        default: led <= 1'b0;
      endcase
    end
  end

endmodule // status_blinker

// File: gpio_bank.sv
// ten-pad gpio bank with axi4-lite registers and status indicator
// assumes pad inputs synchronous to aclk and a pad cell doing pull and tristate
`timescale 1ns/1ps
`include "gpio_bank_consts.svh"

module gpio_bank
  import gpio_bank_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [`NUM_PADS-1:0] pad_i,
  output pad_drive_t pad,
  input wire logic net_wake
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [`NUM_PADS-1:0] dir_q;
  logic [`NUM_PADS-1:0] out_q;
  logic alt_q;
  net_state_t state_q;
  logic led;

  logic [`ADDR_W-1:0] awaddr_q;
  logic aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_have_q;
  logic do_write;

  // merges enabled byte lanes into a 32-bit old value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // known register offsets
  function automatic logic mapped(input logic [`ADDR_W-1:0] a);
    return (a == `REG_DIR) || (a == `REG_OUT) || (a == `REG_IN) ||
           (a == `REG_ALT) || (a == `REG_STATE) || (a == `REG_LEVEL);
  endfunction

  // ---------------------------------------------------------------
  // write channel capture
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
    end else if (do_write) begin
      aw_have_q <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      awaddr_q <= {s_axi_awaddr[`ADDR_W-1:2], 2'b00};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (do_write) begin
      w_have_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
  end

  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) &&
                       !s_axi_bvalid;
      s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready) &&
                      !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic [31:0] dir_n;
  logic [31:0] out_n;
  logic [31:0] alt_n;
  logic [31:0] st_n;
  assign dir_n = merge({22'h000000, dir_q}, wdata_q, wstrb_q);
  assign out_n = merge({22'h000000, out_q}, wdata_q, wstrb_q);
  assign alt_n = merge({31'h00000000, alt_q}, wdata_q, wstrb_q);
  assign st_n = merge({29'h00000000, state_q}, wdata_q, wstrb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q <= `DIR_RST;
    end else if (do_write && awaddr_q == `REG_DIR) begin
      dir_q <= dir_n[`NUM_PADS-1:0];
    end
  end

  // output latch keeps writes to input pads; they reach the pad only once its dir_q bit is set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= `OUT_RST;
    end else if (do_write && awaddr_q == `REG_OUT) begin
      out_q <= out_n[`NUM_PADS-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alt_q <= `ALT_RST;
    end else if (do_write && awaddr_q == `REG_ALT) begin
      alt_q <= alt_n[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= NET_OFF;
    end else if (do_write && awaddr_q == `REG_STATE) begin
      unique case (st_n[`STATE_LSB +: `STATE_W])
        NET_OFF, NET_UNREG, NET_IDLE, NET_PSM, NET_CONNECTING:
          state_q <= net_state_t'(st_n[`STATE_LSB +: `STATE_W]);
        default: state_q <= state_q;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // status indicator
  // ---------------------------------------------------------------
  status_blinker u_blink (
    .aclk(aclk),
    .aresetn(aresetn),
    .net_state(state_q),
    .wake_evt(net_wake),
    .led(led)
  );

  // ---------------------------------------------------------------
  // pad drive
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad.o <= '0;
      pad.oe <= '0;
      pad.weak_pull_down <= '1;
    end else begin
      for (int i = 0; i < `NUM_PADS; i++) begin
        if (i == 0 && alt_q) begin
          pad.o[i] <= led;
          pad.oe[i] <= 1'b1;
          pad.weak_pull_down[i] <= 1'b0;
        end else begin
          pad.o[i] <= dir_q[i] & out_q[i];
          pad.oe[i] <= dir_q[i];
          pad.weak_pull_down[i] <= ~dir_q[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (s_axi_araddr & 8'hfc)
      `REG_DIR: rd_mux = {22'h000000, dir_q};
      `REG_OUT: rd_mux = {22'h000000, out_q};
      `REG_IN: rd_mux = {22'h000000, pad_i};
      `REG_ALT: rd_mux = {31'h00000000, alt_q};
      `REG_STATE: rd_mux = {29'h00000000, state_q};
      `REG_LEVEL: rd_mux = {22'h000000, pad.o};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= mapped(s_axi_araddr & 8'hfc) ? `RESP_OKAY
                                                 : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // gpio_bank

// File: gpio_bank_chk.sv
// checker for gpio_bank: bus answers, holding and pad drive
// bound to gpio_bank below; sees only the top module's ports
`timescale 1ns/1ps
`include "gpio_bank_consts.svh"
module gpio_bank_chk
  import gpio_bank_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pad_drive_t pad
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic w_hs;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  // ----------
  // assertions
  // ----------
  property p_rst;
    disable iff (1'b0)
      !aresetn |=> pad.oe == '0 && pad.weak_pull_down == '1;
  endproperty
  a_rst: assert property (p_rst) else $error("pads driven in reset");
  property p_wr;
    s_axi_awvalid && s_axi_awready && w_hs |=> ##1 s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("write answer late");
  property p_rd;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("bresp dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("rdata dropped");
  property p_wbusy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wbusy: assert property (p_wbusy) else $error("write taken early");
  property p_rbusy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rbusy: assert property (p_rbusy) else $error("read taken early");
  property p_err;
    s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("error read not zero");
  // pads one to nine move only after a write
  property p_pads;
    $changed({pad.o[9:1], pad.oe[9:1], pad.weak_pull_down[9:1]}) |->
      !$past(aresetn) || $past(w_hs) || $past(w_hs, 2) || $past(w_hs, 3);
  endproperty
  a_pads: assert property (p_pads) else $error("pad moved");
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
  c_led: cover property ($rose(pad.o[0]));
  c_rhold: cover property (s_axi_rvalid && !s_axi_rready);
endmodule // gpio_bank_chk

bind gpio_bank gpio_bank_chk gpio_bank_chk_inst (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .pad
);

// File: pad_partner.sv
// external logic sources on the ten pads and the resolved pin level
// the bench sets what each source drives; a bare pin swings each cycle
`timescale 1ns/1ps
module pad_partner
  import gpio_bank_pkg::*;
(
  input wire logic aclk,
  input wire pad_drive_t pad,
  input wire logic [9:0] ext_val,
  input wire logic [9:0] ext_en,
  output logic [9:0] pad_i
);
  logic [9:0] last_q;
  always_ff @(posedge aclk) last_q <= pad_i;
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      if (pad.oe[i])
        pad_i[i] = pad.o[i];
      else if (ext_en[i])
        pad_i[i] = ext_val[i];
      else if (pad.weak_pull_down[i])
        pad_i[i] = 1'b0;
      else
        pad_i[i] = ~last_q[i];
    end
  end
endmodule // pad_partner

// File: tb_gpio_bank_with_status_indicator.sv
// self-checking bench for gpio_bank with a pad partner model
// assumes the checker is bound in; reads are scored from a queue
`timescale 1ns/1ps
module tb_gpio_bank_with_status_indicator
  import gpio_bank_pkg::*;
;
  logic aclk = 0, aresetn = 0, net_wake = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [9:0] ext_val = '0, ext_en = '0, pad_i, v;
  logic [4:0] pat = 5'b10110;
  pad_drive_t pad;
  logic [33:0] q[$];
  int n_errors = 0, cmp_count = 0, cyc = 0, seed = 34786;

  gpio_bank gpio_bank_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pad_i, .pad, .net_wake);
  pad_partner pad_partner_inst (.aclk, .pad, .ext_val, .ext_en, .pad_i);

  initial forever #10 aclk = ~aclk;
  // -----
  // tasks
  // -----
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic ad, wd;
    ad = 0;
    wd = 0;
    q.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      ad = ad | (s_axi_awvalid && s_axi_awready);
      wd = wd | (s_axi_wvalid && s_axi_wready);
      if (ad) s_axi_awvalid <= 0;
      if (wd) s_axi_wvalid <= 0;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1;
    @(posedge aclk);
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    q.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1;
    @(posedge aclk);
    s_axi_rready <= 0;
  endtask

  // answers are scored here as they are taken
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      chk({s_axi_bresp, 32'h0}, q.pop_front());
    if (cyc == 5000) begin
      n_errors++;
      end_of_test();
    end
  end
  // ---------
  // scenarios
  // ---------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk(34'({pad.oe, pad.weak_pull_down}), 34'({10'h0, 10'h3ff}));
    for (int a = 0; a < 24; a += 4)
      rd(8'(a), 32'h0, 2'b00);
    $display("reset test done");
    v = 10'($random(seed));
    ext_val <= v;
    ext_en <= 10'h3ff;
    wr(8'h04, 32'h3ff, 2'b00);
    repeat (3) @(posedge aclk);
    chk(34'(pad.oe), 34'h0);
    rd(8'h08, 32'(v), 2'b00);
    rd(8'h04, 32'h3ff, 2'b00);
    $display("input test done");
    ext_en <= 10'h0;
    wr(8'h00, 32'h3ff, 2'b00);
    for (int k = 0; k < 2; k++) begin
      v = k ? ~v : 10'($random(seed));
      wr(8'h04, 32'(v), 2'b00);
      repeat (3) @(posedge aclk);
      chk(34'({pad.oe, pad.o}), 34'({10'h3ff, v}));
      rd(8'h08, 32'(v), 2'b00);
      rd(8'h14, 32'(v), 2'b00);
    end
    $display("output test done");
    wr(8'h20, 32'h1, 2'b10);
    rd(8'h20, 32'h0, 2'b10);
    wr(8'h08, 32'h0, 2'b00);
    rd(8'h08, 32'(v), 2'b00);
    $display("refusal test done");
    wr(8'h10, 32'h1, 2'b00);
    repeat (3) @(posedge aclk);
    chk(34'(pad.o[0]), 34'(v[0]));
    wr(8'h0c, 32'h1, 2'b00);
    for (int s = 0; s < 5; s++) begin
      wr(8'h10, 32'(s), 2'b00);
      wr(8'h04, {22'h0, v[9:1], ~pat[s]}, 2'b00);
      repeat (3) @(posedge aclk);
      chk(34'(pad.o[0]), 34'(pat[s]));
    end
    wr(8'h10, 32'h3, 2'b00);
    for (int k = 0; k < 2; k++) begin
      net_wake <= 1;
      @(posedge aclk);
      net_wake <= 0;
      repeat (3) @(posedge aclk);
      chk(34'(pad.o[0]), 34'(k == 0));
    end
    $display("indicator test done");
    end_of_test();
  end
endmodule // tb_gpio_bank_with_status_indicator
